/* File: fsh_cycle_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module fsh_cycle_timer #(
	parameter int W = 8
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_load,
	input wire logic [W-1:0] i_count,
	output logic o_done
);
	logic [W-1:0] cnt_q;

	// Counts down to zero; a load of N ends the calling state N cycles later
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			cnt_q <= '0;
		else if (i_load)
			cnt_q <= i_count;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - 1'b1;
	end

	// Done is raised on the last counted cycle so the state change lands on
	// the Nth edge; an idle timer reads as expired
	assign o_done = (cnt_q <= W'(1));
endmodule : fsh_cycle_timer
`default_nettype wire

/* File: fsh_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fsh_flash_model #(
	parameter logic [7:0] PROG_CMD = 8'ha0,
	parameter logic [7:0] AUTOSEL_CMD = 8'hc3,
	parameter logic [7:0] ID_CODE = 8'h3c // Arbitrary identifier value
) (
	input wire logic [16:0] i_addr,
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic i_reset_n,
	input wire logic i_reset_hv,
	input wire logic [7:0] i_dq,
	output logic [7:0] o_dq,
	output logic o_dq_oe
);
	logic [7:0] mem [131072];
	bit written [131072];
	bit [9:0] prot_q;
	logic autosel_q = 1'b0;
	int wake_cnt = 0;
	logic [16:0] wr_addr_q;
	logic [7:0] wr_data_q;
	logic armed_q = 1'b0;
	logic busy_q = 1'b0;
	logic pwr_ok_q = 1'b0;
	logic wr_act;
	logic rd_act;
	int wr_cnt = 0;
	int rd_cnt = 0;
	int prot_cnt = 0;
	realtime t_wr, t_rd, t_rst, wr_ns, rd_ns, rst_ns;

	// Unwritten locations hold a fixed pattern, cheaper than a full array
	function automatic logic [7:0] pat(input logic [16:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction : pat

	// Top boot map: 16K sectors below, then 4K, 4K and 8K at the top
	function automatic int sect(input logic [16:0] a);
		if (a[16:14] != 3'h7)
			return int'(a[16:14]);
		else if (!a[13])
			return 7 + int'(a[12]);
		else
			return 9;
	endfunction : sect

	// Any address change wakes the array; output data stays latched
	// while asleep, so the read mux needs no sleep term
	always @(i_addr) wake_cnt++;

	// Writes before the pins settle at power-up are ignored
	initial #20 pwr_ok_q = 1'b1;

	// Bus operation decode from the strobes
	assign wr_act = !i_ce_n && !i_we_n && i_oe_n && i_reset_n;
	assign rd_act = !i_ce_n && !i_oe_n && i_we_n && i_reset_n;
	assign o_dq_oe = rd_act;

	// Status bits while programming, identifier in autoselect, else array data
	always @*
		if (!rd_act)
			o_dq = 8'h00;
		else if (busy_q)
			o_dq = {~wr_data_q[7], 7'h00};
		else if (autosel_q)
			o_dq = ID_CODE;
		else
			o_dq = written[i_addr] ? mem[i_addr] : pat(i_addr);

	// Command latches: address on entry to write mode, data on exit
	always @(posedge wr_act)
	begin
		t_wr = $realtime;
		wr_addr_q = i_addr;
	end
	always @(negedge wr_act)
		if (pwr_ok_q && i_reset_n)
		begin
			wr_ns = $realtime - t_wr;
			wr_data_q = i_dq;
			wr_cnt++;
			if (i_reset_hv)
			begin
				prot_cnt++;
				prot_q[sect(wr_addr_q)] = !wr_addr_q[6];
			end
			else if (armed_q)
			begin
				// Timer ignores select, so deselecting cannot stop it
				if (!prot_q[sect(wr_addr_q)])
				begin
					mem[wr_addr_q] = i_dq;
					written[wr_addr_q] = 1'b1;
				end
				armed_q = 1'b0;
				busy_q = 1'b1;
				busy_q <= #50 1'b0;
			end
			else
			begin
				armed_q = (i_dq == PROG_CMD);
				autosel_q = (i_dq == AUTOSEL_CMD);
			end
		end

	// Reset pulse aborts work and returns to read-array
	always @(negedge i_reset_n) t_rst = $realtime;
	always @(posedge i_reset_n)
	begin
		rst_ns = $realtime - t_rst;
		armed_q = 1'b0;
		autosel_q = 1'b0;
		busy_q = 1'b0;
	end

	// Read strobe timing
	always @(posedge rd_act)
	begin
		t_rd = $realtime;
		rd_cnt++;
	end
	always @(negedge rd_act) rd_ns = $realtime - t_rd;
endmodule : fsh_flash_model
`default_nettype wire

/* File: fsh_host.sv */
// Overview of operation
// - Read: select and output enable low, write enable and reset high.
// - Command write: select and write enable low, output enable high.
// - In unlock-bypass mode a byte program takes two write cycles.
// - After standby, wait the full select access time before data.
// - Restart a program or erase that a hardware reset cut short; the host only sets a status flag for software.
// - Protect: high-voltage reset, sector address, bit6 direction.
`timescale 1ns/1ps
`default_nettype none
module fsh_host
	import fsh_pkg::*;
#(
	parameter int ADDR_W = 17,
	parameter int DATA_W = 8,
	parameter logic [7:0] BYPASS_PROG_CMD = fsh_pkg::BYPASS_PROG_CMD_DEFAULT
) (
	input wire logic I_CLK,
	input wire logic I_RESET,
	input wire logic [3:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	output logic [ADDR_W-1:0] O_FL_ADDR,
	output logic O_FL_CE_N,
	output logic O_FL_OE_N,
	output logic O_FL_WE_N,
	output logic O_FL_RESET_N,
	output logic O_FL_RESET_HV,
	input wire logic [DATA_W-1:0] I_FL_DQ,
	output logic [DATA_W-1:0] O_FL_DQ,
	output logic O_FL_DQ_OE
);
	import fsh_pkg::*;

	fsh_state_t state_q, state_d;
	logic [2:0] op_q;
	logic [2:0] new_op;
	logic phase_q;
	logic launch;
	logic last_prog_q;
	logic restart_q;
	logic temp_hv_q;
	logic [ADDR_W-1:0] addr_reg_q;
	logic [DATA_W-1:0] wdata_q;
	logic [DATA_W-1:0] rdata_q;
	logic [ADDR_W-1:0] fl_addr_q;
	logic [DATA_W-1:0] dq_q;
	logic ce_n_q, oe_n_q, we_n_q, rst_n_q, hv_q, dq_oe_q;
	logic tmr_load;
	logic [TIMER_W-1:0] tmr_count;
	logic tmr_done;
	logic rd_ack_q;
	logic [31:0] rd_mux;
	logic [31:0] readdata_q;
	logic [1:0] pulse_cnt_q;
	logic [2:0] low_pin;
	logic [TIMER_W-1:0] low_cnt_q [3];

	// Register decode, shared by the write and read paths
	function automatic logic reg_hit(input logic [3:0] a,
		input logic [3:0] idx);
		reg_hit = (a == idx);
	endfunction : reg_hit

	// Address for a protect cycle keeps the sector bits from software
	function automatic logic [ADDR_W-1:0] prot_addr(
		input logic [ADDR_W-1:0] a, input logic unprot);
		logic [ADDR_W-1:0] r;
		r = a;
		r[PROT_DIR_BIT] = unprot;
		r[PROT_SEL_BIT] = 1'b1;
		r[LOW_ADDR_BIT] = 1'b0;
		prot_addr = r;
	endfunction : prot_addr

	fsh_cycle_timer #(
		.W(TIMER_W)
	) u_timer (
		.i_clk(I_CLK),
		.i_reset(I_RESET),
		.i_load(tmr_load),
		.i_count(tmr_count),
		.o_done(tmr_done)
	);

	// A control write only launches when idle; a busy write launches nothing but still loads the hold bit
	assign new_op = I_AVS_WRITEDATA[CTRL_OP_LSB +: 3];
	assign launch = I_AVS_WRITE && reg_hit(I_AVS_ADDRESS, REG_CTRL) &&
		(state_q == ST_IDLE) && (new_op != OP_NONE);

	// Sequencer next state and timer loads
	always_comb
	begin
		state_d = state_q;
		tmr_load = 1'b0;
		tmr_count = '0;
		case (state_q)
			ST_IDLE:
			begin
				if (launch)
				begin
					case (new_op)
						OP_READ:
						begin
							state_d = ST_RD_ACCESS;
							tmr_load = 1'b1;
							tmr_count = TIMER_W'(READ_CYC);
						end
						OP_RESET:
						begin
							state_d = ST_RST_LOW;
							tmr_load = 1'b1;
							tmr_count = TIMER_W'(RESET_PULSE_CYC);
						end
						OP_WRITE, OP_BYPASS_PROG, OP_PROTECT, OP_UNPROTECT:
						begin
							state_d = ST_WR_SETUP;
							tmr_load = 1'b1;
							tmr_count = TIMER_W'(1);
						end
						default:
						begin
							state_d = ST_IDLE;
						end
					endcase
				end
			end
			ST_RD_ACCESS:
			begin
				if (tmr_done)
					state_d = ST_IDLE;
			end
			ST_WR_SETUP:
			begin
				if (tmr_done)
				begin
					state_d = ST_WR_PULSE;
					tmr_load = 1'b1;
					tmr_count = TIMER_W'(WRITE_PULSE_CYC);
				end
			end
			ST_WR_PULSE:
			begin
				if (tmr_done)
				begin
					state_d = ST_WR_HOLD;
					tmr_load = 1'b1;
					tmr_count = TIMER_W'(WRITE_HOLD_CYC);
				end
			end
			ST_WR_HOLD:
			begin
				if (tmr_done)
				begin
					// Bypass program runs a second cycle with the data
					if (op_q == OP_BYPASS_PROG && !phase_q)
					begin
						state_d = ST_WR_SETUP;
						tmr_load = 1'b1;
						tmr_count = TIMER_W'(1);
					end
					else
						state_d = ST_IDLE;
				end
			end
			ST_RST_LOW:
			begin
				if (tmr_done)
				begin
					state_d = ST_RST_RECOVER;
					tmr_load = 1'b1;
					tmr_count = TIMER_W'(RESET_RECOVER_CYC);
				end
			end
			ST_RST_RECOVER:
			begin
				if (tmr_done)
					state_d = ST_IDLE;
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Sequencer state, operation and bypass phase
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
		begin
			state_q <= ST_IDLE;
			op_q <= OP_NONE;
			phase_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			if (launch)
			begin
				op_q <= new_op;
				phase_q <= 1'b0;
			end
			else if (state_q == ST_WR_HOLD && state_d == ST_WR_SETUP)
				phase_q <= 1'b1;
		end
	end

	// Control pins follow the next state so they change with it
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
		begin
			ce_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			we_n_q <= 1'b1;
			rst_n_q <= 1'b1;
			dq_oe_q <= 1'b0;
		end
		else
		begin
			// Select low while reading or in the write pulse; output enable low only while reading
			ce_n_q <= !(state_d == ST_RD_ACCESS ||
				state_d == ST_WR_PULSE);
			oe_n_q <= !(state_d == ST_RD_ACCESS);
			// Write enable low with output enable kept high
			we_n_q <= !(state_d == ST_WR_PULSE);
			rst_n_q <= !(state_d == ST_RST_LOW);
			// Drive data only around a write, never against a read
			dq_oe_q <= (state_d == ST_WR_SETUP ||
				state_d == ST_WR_PULSE ||
				state_d == ST_WR_HOLD);
		end
	end

	// High-voltage reset level for protect cycles or software hold
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
			hv_q <= 1'b0;
		else if (state_d == ST_RST_LOW)
			hv_q <= 1'b0;
		// At launch the new code decides; a stale protect code must not
		// raise the level for one cycle of the next operation
		else if (state_d != ST_IDLE && (launch ?
			(new_op == OP_PROTECT || new_op == OP_UNPROTECT) :
			(op_q == OP_PROTECT || op_q == OP_UNPROTECT)))
			hv_q <= 1'b1;
		else
			hv_q <= temp_hv_q;
	end

	// Address and data pins loaded at launch; data reloaded at bypass phase two
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
		begin
			fl_addr_q <= RST_ADDR;
			dq_q <= RST_DATA;
		end
		else if (launch)
		begin
			if (new_op == OP_PROTECT || new_op == OP_UNPROTECT)
				fl_addr_q <= prot_addr(addr_reg_q,
					new_op == OP_UNPROTECT);
			else
				fl_addr_q <= addr_reg_q;
			dq_q <= (new_op == OP_BYPASS_PROG) ?
				BYPASS_PROG_CMD : wdata_q;
		end
		else if (state_q == ST_WR_HOLD && state_d == ST_WR_SETUP)
			dq_q <= wdata_q;
	end

	// Read data sampled at the end of the full access wait
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
			rdata_q <= RST_DATA;
		else if (state_q == ST_RD_ACCESS && tmr_done)
			rdata_q <= I_FL_DQ;
	end

	// Software registers; set of the restart flag beats its clear
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
		begin
			addr_reg_q <= RST_ADDR;
			wdata_q <= RST_DATA;
			temp_hv_q <= 1'b0;
			last_prog_q <= 1'b0;
			restart_q <= 1'b0;
		end
		else
		begin
			if (I_AVS_WRITE && reg_hit(I_AVS_ADDRESS, REG_ADDR))
				addr_reg_q <= I_AVS_WRITEDATA[ADDR_W-1:0];
			if (I_AVS_WRITE && reg_hit(I_AVS_ADDRESS, REG_WDATA))
				wdata_q <= I_AVS_WRITEDATA[DATA_W-1:0];
			if (I_AVS_WRITE && reg_hit(I_AVS_ADDRESS, REG_CTRL))
				temp_hv_q <= I_AVS_WRITEDATA[CTRL_TEMP_HV_BIT];
			// A reset right after a write may have cut work short
			if (launch)
				last_prog_q <= (new_op != OP_READ && new_op != OP_RESET);
			if (launch && new_op == OP_RESET && last_prog_q)
				restart_q <= 1'b1;
			else if (I_AVS_WRITE && reg_hit(I_AVS_ADDRESS, REG_STATUS) &&
				I_AVS_WRITEDATA[STAT_RESTART_BIT])
				restart_q <= 1'b0;
		end
	end

	// Read mux; unmapped words read as zero
	always_comb
	begin
		rd_mux = 32'h0;
		if (reg_hit(I_AVS_ADDRESS, REG_CTRL))
			rd_mux[CTRL_TEMP_HV_BIT] = temp_hv_q;
		else if (reg_hit(I_AVS_ADDRESS, REG_ADDR))
			rd_mux[ADDR_W-1:0] = addr_reg_q;
		else if (reg_hit(I_AVS_ADDRESS, REG_WDATA))
			rd_mux[DATA_W-1:0] = wdata_q;
		else if (reg_hit(I_AVS_ADDRESS, REG_RDATA))
			rd_mux[DATA_W-1:0] = rdata_q;
		else if (reg_hit(I_AVS_ADDRESS, REG_STATUS))
		begin
			rd_mux[STAT_BUSY_BIT] = (state_q != ST_IDLE);
			rd_mux[STAT_RESTART_BIT] = restart_q;
			rd_mux[STAT_HV_BIT] = hv_q;
		end
	end

	// Reads take one wait cycle so read data comes from a flop
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
		begin
			rd_ack_q <= 1'b0;
			readdata_q <= 32'h0;
		end
		else
		begin
			rd_ack_q <= I_AVS_READ && !rd_ack_q;
			if (I_AVS_READ && !rd_ack_q)
				readdata_q <= rd_mux;
		end
	end

	assign O_AVS_WAITREQUEST = I_AVS_READ && !rd_ack_q;
	assign O_AVS_READDATA = readdata_q;
	assign O_FL_ADDR = fl_addr_q;
	assign O_FL_CE_N = ce_n_q;
	assign O_FL_OE_N = oe_n_q;
	assign O_FL_WE_N = we_n_q;
	assign O_FL_RESET_N = rst_n_q;
	assign O_FL_RESET_HV = hv_q;
	assign O_FL_DQ = dq_q;
	assign O_FL_DQ_OE = dq_oe_q;

	// Low-time counters for output enable, write enable and reset
	assign low_pin = {!rst_n_q, !we_n_q, !oe_n_q};
	generate
		for (genvar g = 0; g < 3; g++)
		begin : g_low
			always_ff @(posedge I_CLK)
			begin
				if (I_RESET || !low_pin[g])
					low_cnt_q[g] <= '0;
				else
					low_cnt_q[g] <= low_cnt_q[g] + 1'b1;
			end
		end
	endgenerate

	// Write pulses seen in the current operation
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET || launch)
			pulse_cnt_q <= 2'h0;
		else if (state_q == ST_WR_PULSE && state_d == ST_WR_HOLD)
			pulse_cnt_q <= pulse_cnt_q + 2'h1;
	end

	AST_READ_LEVELS: assert property (@(posedge I_CLK) disable iff (I_RESET)
		!oe_n_q |-> !ce_n_q && we_n_q && rst_n_q && !dq_oe_q)
		else $error("read levels wrong");
	AST_WRITE_LEVELS: assert property (@(posedge I_CLK) disable iff (I_RESET)
		!we_n_q |-> !ce_n_q && oe_n_q && dq_oe_q)
		else $error("write levels wrong");
	AST_WE_WIDTH: assert property (@(posedge I_CLK) disable iff (I_RESET)
		$rose(we_n_q) |-> low_cnt_q[1] == TIMER_W'(WRITE_PULSE_CYC))
		else $error("write pulse width wrong");
	AST_NO_FIGHT: assert property (@(posedge I_CLK) disable iff (I_RESET)
		dq_oe_q |-> oe_n_q ##1 (dq_oe_q || oe_n_q))
		else $error("data driven while output enabled");
	AST_RESET_QUIET: assert property (@(posedge I_CLK) disable iff (I_RESET)
		!rst_n_q |-> ce_n_q && oe_n_q && we_n_q && !dq_oe_q && !hv_q)
		else $error("bus active during reset");
	AST_RESET_WIDTH: assert property (@(posedge I_CLK) disable iff (I_RESET)
		$rose(rst_n_q) |-> low_cnt_q[2] == TIMER_W'(RESET_PULSE_CYC))
		else $error("reset pulse width wrong");
	AST_READ_WAIT: assert property (@(posedge I_CLK) disable iff (I_RESET)
		$rose(oe_n_q) |-> low_cnt_q[0] == TIMER_W'(READ_CYC) &&
		rdata_q == $past(I_FL_DQ))
		else $error("read wait or capture wrong");
	AST_BYPASS_TWO: assert property (@(posedge I_CLK) disable iff (I_RESET)
		(state_q == ST_WR_HOLD && state_d == ST_IDLE &&
		op_q == OP_BYPASS_PROG) |-> pulse_cnt_q == 2'h2)
		else $error("bypass program not two cycles");
	AST_PROTECT_ADDR: assert property (@(posedge I_CLK) disable iff (I_RESET)
		(!we_n_q && (op_q == OP_PROTECT || op_q == OP_UNPROTECT)) |->
		hv_q && rst_n_q && fl_addr_q[PROT_SEL_BIT] &&
		!fl_addr_q[LOW_ADDR_BIT] &&
		fl_addr_q[PROT_DIR_BIT] == (op_q == OP_UNPROTECT))
		else $error("protect cycle levels wrong");
	AST_RESTART_FLAG: assert property (@(posedge I_CLK) disable iff (I_RESET)
		(launch && new_op == OP_RESET && last_prog_q) |=> restart_q)
		else $error("restart flag not set");
endmodule : fsh_host
`default_nettype wire

/* File: fsh_host_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
	begin \
		tests_run++; \
		if ((e) !== (g)) \
		begin \
			mismatches++; \
			$display("[ERR] %s expected %h seen %h", nm, e, g); \
		end \
	end
module fsh_host_test;
	import fsh_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] av_addr = 4'h0;
	logic av_rd_s = 1'b0;
	logic av_wr_s = 1'b0;
	logic [31:0] av_wdata = 32'h0;
	logic [31:0] rdata, e_v, m_v;
	logic waitreq, ce_n, oe_n, we_n, rst_n, hv, host_oe, fl_oe;
	logic [16:0] fl_addr, a;
	logic [7:0] host_dq, fl_dq, dq_bus, d;
	logic [7:0] bus_last = 8'h00;
	logic rd_chk = 1'b0;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int mismatches = 0;
	int tests_run = 0;
	integer seed = 67;
	int n0, r0;
	localparam logic [7:0] AUTOSEL_CMD = 8'hc3;
	localparam logic [7:0] ID_CODE = 8'h3c; // Arbitrary identifier value

	initial forever #5 clk = ~clk;

	fsh_host u_dut (.I_CLK(clk), .I_RESET(rst), .I_AVS_ADDRESS(av_addr),
		.I_AVS_READ(av_rd_s), .I_AVS_WRITE(av_wr_s),
		.I_AVS_WRITEDATA(av_wdata), .O_AVS_READDATA(rdata),
		.O_AVS_WAITREQUEST(waitreq), .O_FL_ADDR(fl_addr), .O_FL_CE_N(ce_n),
		.O_FL_OE_N(oe_n), .O_FL_WE_N(we_n), .O_FL_RESET_N(rst_n),
		.O_FL_RESET_HV(hv), .I_FL_DQ(dq_bus), .O_FL_DQ(host_dq),
		.O_FL_DQ_OE(host_oe));
	fsh_flash_model #(.AUTOSEL_CMD(AUTOSEL_CMD), .ID_CODE(ID_CODE))
		u_flash (.i_addr(fl_addr), .i_ce_n(ce_n), .i_oe_n(oe_n),
		.i_we_n(we_n), .i_reset_n(rst_n), .i_reset_hv(hv), .i_dq(dq_bus),
		.o_dq(fl_dq), .o_dq_oe(fl_oe));

	// Undriven data pins keep changing so a stale value cannot pass
	assign dq_bus = host_oe ? host_dq : (fl_oe ? fl_dq : ~bus_last);
	always @(posedge clk) bus_last <= dq_bus;

	// Oldest expected read value is compared as each checked read lands
	always @(posedge clk)
		if (av_rd_s && !waitreq && rd_chk)
		begin
			e_v = exp_q.pop_front();
			m_v = msk_q.pop_front();
			`CHK("readdata", e_v, rdata & m_v);
		end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	task automatic give_up;
		mismatches++;
		report_and_stop();
	endtask : give_up

	task automatic av_wr(input logic [3:0] ad, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		av_wr_s <= 1'b1;
		av_addr <= ad;
		av_wdata <= wd;
		do begin @(posedge clk); n++; end while (waitreq !== 1'b0 && n < 50);
		if (n >= 50)
			give_up();
		av_wr_s <= 1'b0;
	endtask : av_wr

	task automatic av_rd(input logic [3:0] ad, input logic chk,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk);
		av_rd_s <= 1'b1;
		av_addr <= ad;
		rd_chk <= chk;
		do begin @(posedge clk); n++; end while (waitreq !== 1'b0 && n < 50);
		if (n >= 50)
			give_up();
		rd = rdata;
		av_rd_s <= 1'b0;
		rd_chk <= 1'b0;
	endtask : av_rd

	task automatic av_chk(input logic [3:0] ad, input logic [31:0] e,
		input logic [31:0] m);
		logic [31:0] rd;
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		av_rd(ad, 1'b1, rd);
	endtask : av_chk

	// Launch an operation and poll busy until it clears
	task automatic run_op(input logic [2:0] op);
		logic [31:0] s;
		int n;
		n = 0;
		av_wr(REG_CTRL, 32'(op));
		do begin av_rd(REG_STATUS, 1'b0, s); n++; end
		while (s[STAT_BUSY_BIT] !== 1'b0 && n < 200);
		if (n >= 200)
			give_up();
	endtask : run_op

	initial
	begin
		#900000;
		give_up();
	end

	// Main sequence
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i <= int'(REG_STATUS); i++)
			av_chk(4'(i), 32'h0, 32'hffffffff);
		av_wr(4'h9, 32'($random(seed)));
		av_chk(4'h9, 32'h0, 32'hffffffff);
		`CHK("standby ce_n", 1'b1, ce_n);
		`CHK("standby dq_oe", 1'b0, fl_oe);
		// Default array read at a random address
		a = 17'($random(seed));
		av_wr(REG_ADDR, 32'(a));
		run_op(OP_READ);
		av_chk(REG_RDATA, 32'(a[7:0] ^ a[15:8] ^ 8'h5a), 32'hff);
		`CHK("oe ns", READ_CYC * CLK_PERIOD_NS, int'(u_flash.rd_ns));
		// Write cycle; a launch while busy must be dropped. Bit 7 is
		// cleared so the data never matches a model command code
		a = 17'($random(seed));
		d = 8'($random(seed)) & 8'h7f;
		av_wr(REG_ADDR, 32'(a));
		av_wr(REG_WDATA, 32'(d));
		n0 = u_flash.wr_cnt;
		r0 = u_flash.rd_cnt;
		av_wr(REG_CTRL, 32'(OP_WRITE));
		av_wr(REG_CTRL, 32'(OP_READ));
		run_op(OP_NONE);
		`CHK("writes", n0 + 1, u_flash.wr_cnt);
		`CHK("reads", r0, u_flash.rd_cnt);
		`CHK("wr addr", a, u_flash.wr_addr_q);
		`CHK("wr data", d, u_flash.wr_data_q);
		`CHK("we ns", WRITE_PULSE_CYC * 10, int'(u_flash.wr_ns));
		// Bypass program then read back
		a = 17'($random(seed));
		d = 8'($random(seed));
		av_wr(REG_ADDR, 32'(a));
		av_wr(REG_WDATA, 32'(d));
		n0 = u_flash.wr_cnt;
		run_op(OP_BYPASS_PROG);
		`CHK("bypass writes", n0 + 2, u_flash.wr_cnt);
		run_op(OP_READ);
		av_chk(REG_RDATA, 32'(d), 32'hff);
		// Identifier read after the autoselect command
		av_wr(REG_WDATA, 32'(AUTOSEL_CMD));
		run_op(OP_WRITE);
		run_op(OP_READ);
		av_chk(REG_RDATA, 32'(ID_CODE), 32'hff);
		// Reset cuts off an armed program; restart flag set then cleared
		a = 17'($random(seed));
		av_wr(REG_ADDR, 32'(a));
		av_wr(REG_WDATA, 32'h000000a0);
		run_op(OP_WRITE);
		run_op(OP_RESET);
		`CHK("rst ns", RESET_PULSE_CYC * 10, int'(u_flash.rst_ns));
		av_chk(REG_STATUS, 32'h2, 32'h7);
		av_wr(REG_STATUS, 32'h2);
		av_chk(REG_STATUS, 32'h0, 32'h7);
		av_wr(REG_WDATA, 32'($random(seed)) & 32'h7f);
		run_op(OP_WRITE);
		run_op(OP_READ);
		av_chk(REG_RDATA, 32'(a[7:0] ^ a[15:8] ^ 8'h5a), 32'hff);
		// Protect and unprotect address forms
		for (int k = 0; k < 2; k++)
		begin
			a = 17'($random(seed));
			av_wr(REG_ADDR, 32'(a));
			n0 = u_flash.prot_cnt;
			run_op(k ? OP_UNPROTECT : OP_PROTECT);
			`CHK("prot cnt", n0 + 1, u_flash.prot_cnt);
			`CHK("prot addr", {a[16:7], k[0], a[5:2], 2'b10},
				u_flash.wr_addr_q);
		end
		// High-voltage hold from the control register
		av_wr(REG_CTRL, 32'h100);
		av_chk(REG_STATUS, 32'h4, 32'h4);
		av_chk(REG_CTRL, 32'h100, 32'hffffffff);
		`CHK("hv on", 1'b1, hv);
		av_wr(REG_CTRL, 32'h0);
		// The pin follows the hold bit one edge after it is written
		repeat (2) @(posedge clk);
		`CHK("hv off", 1'b0, hv);
		// Controller reset with the hold bit set returns pins to idle
		av_wr(REG_CTRL, 32'h100);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK("hv after reset", 1'b0, hv);
		`CHK("ce_n after reset", 1'b1, ce_n);
		av_chk(REG_CTRL, 32'h0, 32'hffffffff);
		report_and_stop();
	end
endmodule : fsh_host_test
`default_nettype wire

/* File: fsh_pkg.sv */
`default_nettype none
package fsh_pkg;
	// Timing figures in nanoseconds and the derived cycle counts
	localparam int CLK_PERIOD_NS = 10;
	localparam int ADDRESS_ACCESS_TIME_NS = 90;
	localparam int SELECT_ACCESS_TIME_NS = 90;
	localparam int READ_WAIT_NS =
		(ADDRESS_ACCESS_TIME_NS > SELECT_ACCESS_TIME_NS) ?
		ADDRESS_ACCESS_TIME_NS : SELECT_ACCESS_TIME_NS;
	localparam int READ_CYC =
		(READ_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_PULSE_NS = 50;
	localparam int WRITE_PULSE_CYC =
		(WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_HOLD_NS = 10;
	localparam int WRITE_HOLD_CYC =
		(WRITE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_PULSE_MIN_TIME_NS = 500;
	localparam int RESET_PULSE_CYC =
		(RESET_PULSE_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_RECOVER_NS = 50;
	localparam int RESET_RECOVER_CYC =
		(RESET_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W = 8;

	// Register word indices
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h1;
	localparam logic [3:0] REG_WDATA = 4'h2;
	localparam logic [3:0] REG_RDATA = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;

	// Field positions
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_TEMP_HV_BIT = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_RESTART_BIT = 1;
	localparam int STAT_HV_BIT = 2;
	localparam int PROT_DIR_BIT = 6;
	localparam int PROT_SEL_BIT = 1;
	localparam int LOW_ADDR_BIT = 0;

	// Operation codes written to the control register
	localparam logic [2:0] OP_NONE = 3'h0;
	localparam logic [2:0] OP_READ = 3'h1;
	localparam logic [2:0] OP_WRITE = 3'h2;
	localparam logic [2:0] OP_BYPASS_PROG = 3'h3;
	localparam logic [2:0] OP_RESET = 3'h4;
	localparam logic [2:0] OP_PROTECT = 3'h5;
	localparam logic [2:0] OP_UNPROTECT = 3'h6;

	// Reset values and the default bypass program command
	localparam logic [16:0] RST_ADDR = 17'h00000;
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [7:0] BYPASS_PROG_CMD_DEFAULT = 8'ha0;

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_RD_ACCESS,
		ST_WR_SETUP,
		ST_WR_PULSE,
		ST_WR_HOLD,
		ST_RST_LOW,
		ST_RST_RECOVER
	} fsh_state_t;
endpackage : fsh_pkg
`default_nettype wire
